// File: inc/mwe_consts.svh
// Constants of the memory word check-bit network: widths, fields, codes
`ifndef MWE_CONSTS_SVH
`define MWE_CONSTS_SVH

// Word layout: data in the low bits, check bits above it
`define MWE_DATA_W 16
`define MWE_CHK_W 6
`define MWE_WORD_W 22
`define MWE_SYN_W 5
`define MWE_DATA_LSB 0
`define MWE_CHK_LSB 16
`define MWE_PAR_BIT 21

// Syndrome patterns (syndrome bits 4..0) for data bits 0 to 15
`define MWE_PAT_D0 5'h03
`define MWE_PAT_D1 5'h05
`define MWE_PAT_D2 5'h07
`define MWE_PAT_D3 5'h09
`define MWE_PAT_D4 5'h0B
`define MWE_PAT_D5 5'h0C
`define MWE_PAT_D6 5'h0D
`define MWE_PAT_D7 5'h0E
`define MWE_PAT_D8 5'h11
`define MWE_PAT_D9 5'h12
`define MWE_PAT_D10 5'h13
`define MWE_PAT_D11 5'h14
`define MWE_PAT_D12 5'h16
`define MWE_PAT_D13 5'h18
`define MWE_PAT_D14 5'h1A
`define MWE_PAT_D15 5'h1C

// Syndrome patterns for check bits 0 to 4; check bit 5 is the parity bit
`define MWE_PAT_C0 5'h01
`define MWE_PAT_C1 5'h02
`define MWE_PAT_C2 5'h04
`define MWE_PAT_C3 5'h08
`define MWE_PAT_C4 5'h10
`define MWE_PAT_NONE 5'h00

// Reset values
`define MWE_RST_WORD 22'h000000
`define MWE_RST_DATA 16'h0000
`define MWE_RST_SYN 6'h00
`define MWE_RST_CODE 6'h00
`define MWE_RST_CNT 8'h00
`define MWE_CNT_MAX 8'hFF

`endif

// File: inc/mwe_pkg.sv
// Types and shared parity functions of the memory word check-bit network
`include "mwe_consts.svh"

package mwe_pkg;

  // Read classification
  typedef enum logic [1:0] {
    MWE_GOOD = 2'b00,
    MWE_ONE = 2'b01,
    MWE_MANY = 2'b10
  } mwe_class_t;

  // Syndrome pattern of stored bit idx (0-15 data, 16-20 check 0-4)
  function automatic logic [4:0] mwe_pat(input int unsigned idx);
    case (idx)
      0: return `MWE_PAT_D0;
      1: return `MWE_PAT_D1;
      2: return `MWE_PAT_D2;
      3: return `MWE_PAT_D3;
      4: return `MWE_PAT_D4;
      5: return `MWE_PAT_D5;
      6: return `MWE_PAT_D6;
      7: return `MWE_PAT_D7;
      8: return `MWE_PAT_D8;
      9: return `MWE_PAT_D9;
      10: return `MWE_PAT_D10;
      11: return `MWE_PAT_D11;
      12: return `MWE_PAT_D12;
      13: return `MWE_PAT_D13;
      14: return `MWE_PAT_D14;
      15: return `MWE_PAT_D15;
      16: return `MWE_PAT_C0;
      17: return `MWE_PAT_C1;
      18: return `MWE_PAT_C2;
      19: return `MWE_PAT_C3;
      20: return `MWE_PAT_C4;
      default: return `MWE_PAT_NONE;
    endcase
  endfunction

  // Parity groups 0 to 4 over data, folded with the given check bits
  function automatic logic [4:0] mwe_groups(input logic [15:0] data,
                                            input logic [4:0] chk);
    logic [4:0] s;
    logic [4:0] p;
    s = chk;
    for (int unsigned i = 0; i < `MWE_DATA_W; i++) begin
      p = mwe_pat(i);
      for (int unsigned j = 0; j < `MWE_SYN_W; j++) begin
        if (p[j]) begin
          s[j] = s[j] ^ data[i];
        end
      end
    end
    return s;
  endfunction

endpackage

// File: rtl/mwe_core.sv
// Check-bit generator and read checker/corrector for one memory module
//
// Contract
// - This module holds its own correction network for every access here.
// - Each write derives six check bits from the incoming data word.
// - Check bits sit above the 16 data bits in a 22-bit word.
// - Each read recomputes parity groups folded with stored check bits.
// - Overall parity is the XOR of all six syndrome bits.
// - Syndrome bit five only builds the overall parity, never locates.
// - Overall parity zero means even flips, one means odd flips.
// - Syndrome bits zero to four all zero with overall parity zero classifies the word good.
// - Every stored bit except the parity bit owns a distinct nonzero syndrome pattern.
// - Data bit two feeds syndrome bits zero, one and two.
// - Data bit one feeds syndrome bits zero and two only.
// - Codes 1,2,4,10,20 octal are check bits; listed codes are data bits.
// - Resulting error code is kept in a readable error status register.
// - A single-bit error inverts the located bit before data leaves.
// - Unassigned syndrome codes are fatal multiple errors, never corrected.
// - Overall parity and syndrome sort reads into good, single, multiple.
`timescale 1ns/1ps
`include "mwe_consts.svh"

module mwe_core
  import mwe_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WR_REQ,
  input wire logic [15:0] WR_DATA,
  output logic STORE_WE,
  output logic [21:0] STORE_WORD,
  input wire logic RD_REQ,
  input wire logic [21:0] RD_WORD,
  output logic RD_VALID,
  output logic [15:0] RD_DATA,
  output logic [5:0] SYNDROME_BITS,
  output logic OVERALL_PARITY,
  output logic ONE_BIT_ERROR_CLASS,
  output logic MANY_BIT_ERROR_CLASS,
  output logic CHECK_BIT_FAULT_CODE,
  output logic DATA_BIT_FAULT_CODE,
  input wire logic STATUS_CLR,
  output logic [5:0] PARITY_ERROR_STATUS,
  output logic STATUS_VALID,
  output logic STATUS_FATAL,
  output logic [7:0] SINGLE_COUNT
);
  import mwe_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    logic store_we;
    logic [21:0] store_word;
    logic rd_valid;
    logic [15:0] rd_data;
    logic [5:0] syndrome;
    logic overall_parity;
    mwe_class_t cls;
    logic chk_fault;
    logic data_fault;
    logic [5:0] status;
    logic status_valid;
    logic status_fatal;
    logic [7:0] single_count;
  } mwe_state_t;

  localparam mwe_state_t MWE_RESET = '{
    store_we: 1'b0,
    store_word: `MWE_RST_WORD,
    rd_valid: 1'b0,
    rd_data: `MWE_RST_DATA,
    syndrome: `MWE_RST_SYN,
    overall_parity: 1'b0,
    cls: MWE_GOOD,
    chk_fault: 1'b0,
    data_fault: 1'b0,
    status: `MWE_RST_CODE,
    status_valid: 1'b0,
    status_fatal: 1'b0,
    single_count: `MWE_RST_CNT
  };

  mwe_state_t st;
  mwe_state_t next_st;

  // Write side terms
  logic [4:0] wr_chk;
  logic wr_par;
  logic [21:0] wr_word;

  // Read side terms
  logic [15:0] rd_d;
  logic [5:0] rd_c;
  logic [4:0] syn;
  logic overall_parity;
  logic syn_top;
  logic [21:0] flip_mask;
  logic assigned;
  logic check_hit;
  logic data_hit;
  mwe_class_t rd_cls;
  logic [15:0] fixed_data;
  logic [5:0] err_code;

  // Check bits 0-4 are group parities of the data alone; bit 5 then
  // makes the whole word even so that a clean word reads odd-free
  assign wr_chk = mwe_groups(WR_DATA, 5'h00);
  assign wr_par = ^{wr_chk, WR_DATA};
  assign wr_word = {wr_par, wr_chk, WR_DATA};

  // Split the returned word into its data and check fields
  assign rd_d = RD_WORD[`MWE_CHK_LSB-1:`MWE_DATA_LSB];
  assign rd_c = RD_WORD[`MWE_WORD_W-1:`MWE_CHK_LSB];

  // Recompute groups and fold in stored check bits 0-4
  assign syn = mwe_groups(rd_d, rd_c[4:0]);

  // Total parity of all 22 bits; syndrome bit 5 is derived from it so
  // that the XOR of all six syndrome bits equals that total
  assign overall_parity = ^RD_WORD;
  assign syn_top = overall_parity ^ (^syn);

  // Locate the faulty position from syndrome bits 0-4 and overall parity, not syndrome bit 5
  mwe_locate u_locate (
    .syndrome(syn),
    .overall_parity(overall_parity),
    .flip_mask(flip_mask),
    .assigned(assigned),
    .check_hit(check_hit),
    .data_hit(data_hit)
  );

  // Sort the read: even parity with a clean syndrome is good, odd
  // parity with a known pattern is one flip, anything else is fatal
  always_comb begin
    if (!overall_parity && syn == 5'h00) begin
      rd_cls = MWE_GOOD;
    end else if (overall_parity && assigned) begin
      rd_cls = MWE_ONE;
    end else begin
      rd_cls = MWE_MANY;
    end
  end

  // Invert only on a correctable error; fatal words pass unaltered so
  // that a guessed fix never hides a double flip
  assign fixed_data = (rd_cls == MWE_ONE) ?
                      (rd_d ^ flip_mask[15:0]) : rd_d;

  // Reported code: overall parity on top, then syndrome bits 4..0
  assign err_code = {overall_parity, syn};

  // Next state
  always_comb begin
    next_st = st;

    // Write path: one registered word per request
    next_st.store_we = WR_REQ;
    if (WR_REQ) begin
      next_st.store_word = wr_word;
    end

    // Read path: data and all flags are captured in the same edge
    next_st.rd_valid = RD_REQ;
    if (RD_REQ) begin
      next_st.rd_data = fixed_data;
      next_st.syndrome = {syn_top, syn};
      next_st.overall_parity = overall_parity;
      next_st.cls = rd_cls;
      next_st.chk_fault = (rd_cls == MWE_ONE) && check_hit;
      next_st.data_fault = (rd_cls == MWE_ONE) && data_hit;
    end

    // Software clear of the status register
    if (STATUS_CLR) begin
      next_st.status_valid = 1'b0;
      next_st.status_fatal = 1'b0;
      next_st.status = `MWE_RST_CODE;
    end

    // A new error is applied after the clear, so it wins the cycle.
    // A held fatal code is not displaced by a later single error.
    if (RD_REQ && rd_cls != MWE_GOOD) begin
      if (rd_cls == MWE_MANY) begin
        next_st.status = err_code;
        next_st.status_fatal = 1'b1;
        next_st.status_valid = 1'b1;
      end else if (!next_st.status_fatal) begin
        next_st.status = err_code;
        next_st.status_valid = 1'b1;
      end
    end

    // Corrected reads are counted, saturating at the top
    if (RD_REQ && rd_cls == MWE_ONE &&
        st.single_count != `MWE_CNT_MAX) begin
      next_st.single_count = st.single_count + 8'h01;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st <= MWE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign STORE_WE = st.store_we;
  assign STORE_WORD = st.store_word;
  assign RD_VALID = st.rd_valid;
  assign RD_DATA = st.rd_data;
  assign SYNDROME_BITS = st.syndrome;
  assign OVERALL_PARITY = st.overall_parity;
  // Error class codes are one-hot and good is all zero, so each flag is a flop bit with no decode
  assign ONE_BIT_ERROR_CLASS = st.cls[0];
  assign MANY_BIT_ERROR_CLASS = st.cls[1];
  assign CHECK_BIT_FAULT_CODE = st.chk_fault;
  assign DATA_BIT_FAULT_CODE = st.data_fault;
  assign PARITY_ERROR_STATUS = st.status;
  assign STATUS_VALID = st.status_valid;
  assign STATUS_FATAL = st.status_fatal;
  assign SINGLE_COUNT = st.single_count;

endmodule

// File: rtl/mwe_locate.sv
// Syndrome decoder: turns syndrome bits 0-4 and parity into a flip mask
`timescale 1ns/1ps
`include "mwe_consts.svh"

module mwe_locate
  import mwe_pkg::*;
(
  input wire logic [4:0] syndrome,
  input wire logic overall_parity,
  output logic [21:0] flip_mask,
  output logic assigned,
  output logic check_hit,
  output logic data_hit
);

  // One compare per stored bit; syndrome bit 5 never locates
  always_comb begin
    flip_mask = 22'h000000;
    for (int unsigned i = 0; i < 21; i++) begin
      if (syndrome != 5'h00 && mwe_pat(i) == syndrome) begin
        flip_mask[i] = 1'b1;
      end
    end
    // Clean syndrome with odd parity can only be the parity bit itself
    if (syndrome == 5'h00 && overall_parity) begin
      flip_mask[`MWE_PAR_BIT] = 1'b1;
    end
  end

  // Codes with no bit behind them stay unassigned
  assign assigned = |flip_mask;
  assign check_hit = |flip_mask[21:16];
  assign data_hit = |flip_mask[15:0];

endmodule

// File: testbench/mwe_core_sva.sv
// Concurrent checks on the ports of the check-bit network
`timescale 1ns/1ps

module mwe_core_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic WR_REQ,
  input wire logic [15:0] WR_DATA,
  input wire logic STORE_WE,
  input wire logic [21:0] STORE_WORD,
  input wire logic RD_REQ,
  input wire logic [21:0] RD_WORD,
  input wire logic RD_VALID,
  input wire logic [15:0] RD_DATA,
  input wire logic [5:0] SYNDROME_BITS,
  input wire logic OVERALL_PARITY,
  input wire logic ONE_BIT_ERROR_CLASS,
  input wire logic MANY_BIT_ERROR_CLASS,
  input wire logic CHECK_BIT_FAULT_CODE,
  input wire logic DATA_BIT_FAULT_CODE,
  input wire logic STATUS_CLR,
  input wire logic [5:0] PARITY_ERROR_STATUS,
  input wire logic STATUS_VALID,
  input wire logic STATUS_FATAL,
  input wire logic [7:0] SINGLE_COUNT
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // A read taken, then its answer one edge later
  sequence s_rd_taken;
    RD_REQ ##1 RD_VALID;
  endsequence

  // Even parity with a nonzero syndrome is an even count of flips, a fatal read
  sequence s_even_bad;
    RD_VALID && !OVERALL_PARITY && SYNDROME_BITS[4:0] != 5'h00;
  endsequence

  chk_wr_answer: assert property (WR_REQ |=> STORE_WE &&
    STORE_WORD[15:0] == $past(WR_DATA)) else $error("store answer wrong");
  chk_store_even: assert property (STORE_WE |-> !(^STORE_WORD))
    else $error("stored word not even parity");
  chk_rd_answer: assert property (RD_REQ |=> RD_VALID)
    else $error("read answer missing");
  chk_parity_word: assert property (s_rd_taken |->
    OVERALL_PARITY == ^$past(RD_WORD)) else $error("overall parity wrong");
  chk_s5_fold: assert property (RD_VALID |->
    OVERALL_PARITY == ^SYNDROME_BITS) else $error("syndrome five wrong");
  chk_good_pass: assert property (RD_VALID && !OVERALL_PARITY &&
    SYNDROME_BITS[4:0] == 5'h00 |-> !ONE_BIT_ERROR_CLASS &&
    !MANY_BIT_ERROR_CLASS && RD_DATA == $past(RD_WORD[15:0]))
    else $error("good read mishandled");
  chk_even_fatal: assert property (s_even_bad |-> MANY_BIT_ERROR_CLASS &&
    !ONE_BIT_ERROR_CLASS && STATUS_FATAL) else $error("double not fatal");
  chk_fatal_hold: assert property (STATUS_FATAL && !STATUS_CLR |=>
    STATUS_FATAL) else $error("fatal status lost");
  chk_clr_status: assert property (STATUS_CLR && !RD_REQ |=>
    !STATUS_VALID && !STATUS_FATAL) else $error("status not cleared");
  chk_single_code: assert property (RD_VALID && ONE_BIT_ERROR_CLASS &&
    !STATUS_FATAL |-> STATUS_VALID && PARITY_ERROR_STATUS ==
    {OVERALL_PARITY, SYNDROME_BITS[4:0]}) else $error("single code wrong");
endmodule

// File: testbench/mwe_store_model.sv
// Storage array stand-in: keeps the last committed word, returns it
`timescale 1ns/1ps

module mwe_store_model (
  input wire logic clk,
  input wire logic we,
  input wire logic [21:0] word_in,
  input wire logic rd_sel,
  input wire logic [21:0] flip,
  output logic [21:0] word_out
);
  logic [21:0] mem = 22'h000000;

  // Commit the full 22-bit word, check bits and all
  always_ff @(posedge clk) begin
    if (we) begin
      mem <= word_in;
    end
  end

  // Deselected array shows the inverse, so a stale word never looks fresh
  assign word_out = rd_sel ? (mem ^ flip) : ~mem;
endmodule

// File: testbench/tb_top.sv
// Self-checking bench for the memory word check-bit network
`timescale 1ns/1ps

module tb_top;
  import mwe_pkg::*;
  logic clk, rst_n, wr_req, rd_req, status_clr, store_we, rd_valid, ovp;
  logic one_c, many_c, chk_f, dat_f, st_valid, st_fatal;
  logic [15:0] wr_data, rd_data;
  logic [21:0] store_word, rd_word, flip;
  logic [5:0] syn, err_status;
  logic [7:0] single_count;
  int fail_count = 0;
  int n_tests = 0;
  // Syndrome of each stored bit: data 0-15, check 0-4, parity bit last
  logic [4:0] pat [22] = '{5'h03, 5'h05, 5'h07, 5'h09, 5'h0B, 5'h0C,
    5'h0D, 5'h0E, 5'h11, 5'h12, 5'h13, 5'h14, 5'h16, 5'h18, 5'h1A,
    5'h1C, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};

  mwe_core DUT (.CLK(clk), .RST_N(rst_n), .WR_REQ(wr_req),
    .WR_DATA(wr_data), .STORE_WE(store_we), .STORE_WORD(store_word),
    .RD_REQ(rd_req), .RD_WORD(rd_word), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .SYNDROME_BITS(syn), .OVERALL_PARITY(ovp),
    .ONE_BIT_ERROR_CLASS(one_c), .MANY_BIT_ERROR_CLASS(many_c),
    .CHECK_BIT_FAULT_CODE(chk_f), .DATA_BIT_FAULT_CODE(dat_f),
    .STATUS_CLR(status_clr), .PARITY_ERROR_STATUS(err_status),
    .STATUS_VALID(st_valid), .STATUS_FATAL(st_fatal),
    .SINGLE_COUNT(single_count));

  mwe_store_model ARRAY (.clk(clk), .we(store_we), .word_in(store_word),
    .rd_sel(rd_req), .flip(flip), .word_out(rd_word));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  // Expected word built bit by bit, independent of the design's functions
  function automatic logic [21:0] enc(input logic [15:0] d);
    logic [4:0] c;
    c = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (d[i]) begin
        c = c ^ pat[i];
      end
    end
    return {^{c, d}, c, d};
  endfunction

  task automatic do_write(input logic [15:0] d);
    @(negedge clk);
    wr_req = 1'b1;
    wr_data = d;
    @(negedge clk);
    wr_req = 1'b0;
    cmp(store_we, 1'b1);
    cmp(store_word, enc(d));
  endtask

  task automatic do_read(input logic [21:0] f);
    @(negedge clk);
    rd_req = 1'b1;
    flip = f;
    @(negedge clk);
    rd_req = 1'b0;
    flip = 22'h000000;
    cmp(rd_valid, 1'b1);
  endtask

  task automatic t_encode();
    for (int i = 0; i < 16; i++) begin
      do_write(16'h0001 << i);
      if (i == 1) cmp(store_word[20:16], 5'h05);
      if (i == 2) cmp(store_word[20:16], 5'h07);
    end
  endtask

  // Every single flip is located, corrected and reported
  task automatic t_singles();
    do_write(16'hA5C3);
    do_read(22'h000000);
    cmp({one_c, many_c, syn[4:0], rd_data}, {7'h00, 16'hA5C3});
    for (int b = 0; b < 22; b++) begin
      do_read(22'h000001 << b);
      cmp({ovp, syn[4:0]}, {1'b1, pat[b]});
      cmp(rd_data, 16'hA5C3);
      cmp({one_c, many_c}, 2'b10);
      cmp({chk_f, dat_f}, {b > 15, b < 16});
      cmp(err_status, {1'b1, pat[b]});
    end
  endtask

  // Doubles and unassigned odd codes pass uncorrected and stick as fatal
  task automatic t_fatal();
    do_read(22'h000003);
    cmp({many_c, rd_data}, {1'b1, 16'hA5C0});
    cmp({st_fatal, err_status}, {1'b1, 6'h06});
    do_read(22'h000010);
    cmp({one_c, rd_data, err_status}, {1'b1, 16'hA5C3, 6'h06});
    do_read(22'h260000);
    cmp({many_c, one_c, err_status}, {2'b10, 6'h26});
    cmp(single_count, 8'h17);
    @(negedge clk);
    status_clr = 1'b1;
    @(negedge clk);
    status_clr = 1'b0;
    cmp({st_valid, st_fatal, err_status}, 8'h00);
    // Clear and a new single error on one edge: the error is kept
    @(negedge clk);
    {status_clr, rd_req} = 2'h3;
    flip = 22'h000010;
    @(negedge clk);
    {status_clr, rd_req} = 2'h0;
    flip = 22'h000000;
    cmp({st_valid, st_fatal, err_status}, {2'h2, 1'b1, pat[4]});
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    {rst_n, wr_req, rd_req, status_clr} = 4'h0;
    wr_data = 16'h0000;
    flip = 22'h000000;
    repeat (3) @(negedge clk);
    cmp({store_we, rd_valid, st_valid, st_fatal, single_count}, 12'h000);
    rst_n = 1'b1;
    t_encode();
    t_singles();
    t_fatal();
    finish_test();
  end

  // Whole run needs about 93 cycles
  initial begin
    #(5000 * 8);
    fail_count++;
    finish_test();
  end
endmodule

bind mwe_core mwe_core_sva CHK (.CLK(CLK), .RST_N(RST_N), .WR_REQ(WR_REQ),
  .WR_DATA(WR_DATA), .STORE_WE(STORE_WE), .STORE_WORD(STORE_WORD),
  .RD_REQ(RD_REQ), .RD_WORD(RD_WORD), .RD_VALID(RD_VALID),
  .RD_DATA(RD_DATA), .SYNDROME_BITS(SYNDROME_BITS),
  .OVERALL_PARITY(OVERALL_PARITY), .ONE_BIT_ERROR_CLASS(ONE_BIT_ERROR_CLASS),
  .MANY_BIT_ERROR_CLASS(MANY_BIT_ERROR_CLASS),
  .CHECK_BIT_FAULT_CODE(CHECK_BIT_FAULT_CODE),
  .DATA_BIT_FAULT_CODE(DATA_BIT_FAULT_CODE), .STATUS_CLR(STATUS_CLR),
  .PARITY_ERROR_STATUS(PARITY_ERROR_STATUS), .STATUS_VALID(STATUS_VALID),
  .STATUS_FATAL(STATUS_FATAL), .SINGLE_COUNT(SINGLE_COUNT));
